//--- hw/fgsr_map.svh
// field positions, reset value and transfer counts of the filter and gain settings register
`ifndef FGSR_MAP_SVH
`define FGSR_MAP_SVH

`define FGSR_REG_W        8
`define FGSR_RESET_VAL    8'h00
`define FGSR_CORNER_MSB   7
`define FGSR_CORNER_LSB   3
`define FGSR_PRE_BIT      2
`define FGSR_POST_BIT     1
`define FGSR_VGA_BIT      0
`define FGSR_XFER_BITS    4'h8
`define FGSR_CORNER_OFF   5'h00

`endif

//--- hw/fgsr_pkg.sv
// types shared by the filter and gain settings register block
package fgsr_pkg;

  typedef enum logic [1:0] {
    FGSR_IDLE = 2'b00,
    FGSR_CMD  = 2'b01,
    FGSR_WR   = 2'b10,
    FGSR_RD   = 2'b11
  } fgsr_state_t;

  // one shared set of settings drives both channels
  typedef struct packed {
    logic       signal_on;
    logic [4:0] corner_mhz;
    logic       buf_gain_6db;
    logic       post_gain_12db;
    logic       vga_max_28db;
  } fgsr_settings_t;

  // serial port pins as seen from the device
  typedef struct packed {
    logic transfer_strobe_n;
    logic shift_clk;
    logic serial_data;
    logic chip_on_pin;
  } fgsr_pins_t;

endpackage : fgsr_pkg

//--- hw/fgsr_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module fgsr_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : fgsr_sync

//--- hw/fgsr_top.sv
// filter and gain settings register with its three-wire serial port
`timescale 1ns/10ps
`include "fgsr_map.svh"

module fgsr_top
  import fgsr_pkg::*;
#(
  parameter int REG_W = `FGSR_REG_W
) (
  // clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  // serial port and enable pins
  input  wire logic                      transfer_strobe_n_i,
  input  wire logic                      shift_clk_i,
  input  wire logic                      serial_data_i,
  input  wire logic                      chip_on_pin_i,
  output logic                           serial_readback_out_o,
  // shared settings for both channels
  output fgsr_pkg::fgsr_settings_t       settings_o
);
  import fgsr_pkg::*;

  fgsr_pins_t  pins_a;
  fgsr_pins_t  pins_s;
  fgsr_state_t st_q;
  logic        sclk_prev_q;
  logic        rise;
  logic        fall;
  logic [3:0]  cnt_q;
  logic [REG_W-1:0] shift_q;
  logic [REG_W-1:0] reg_q;
  logic        commit;
  logic        rd_bit;

  // settings decode for one shared register
  function automatic fgsr_settings_t decode(input logic [REG_W-1:0] r, input logic on);
    fgsr_settings_t s;
    s.corner_mhz     = r[`FGSR_CORNER_MSB:`FGSR_CORNER_LSB];
    s.signal_on      = on && (r[`FGSR_CORNER_MSB:`FGSR_CORNER_LSB] != `FGSR_CORNER_OFF);
    s.buf_gain_6db   = r[`FGSR_PRE_BIT];
    s.post_gain_12db = r[`FGSR_POST_BIT];
    s.vga_max_28db   = r[`FGSR_VGA_BIT];
    return on ? s : '0;
  endfunction : decode

  assign pins_a.transfer_strobe_n = transfer_strobe_n_i;
  assign pins_a.shift_clk         = shift_clk_i;
  assign pins_a.serial_data       = serial_data_i;
  assign pins_a.chip_on_pin       = chip_on_pin_i;

  fgsr_sync #(
    .W($bits(fgsr_pins_t))
  ) u_sync (
    .clock_i(clock_i),
    .rst_i  (rst_i),
    .async_i(pins_a),
    .sync_o (pins_s)
  );

  // shift clock is only sampled, so edges come from the synced copy
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= pins_s.shift_clk;
    end
  end

  assign rise   = pins_s.shift_clk && !sclk_prev_q;
  assign fall   = !pins_s.shift_clk && sclk_prev_q;
  // a short write is dropped rather than applied half-shifted
  assign commit = (st_q == FGSR_WR) && (cnt_q == `FGSR_XFER_BITS) &&
                  pins_s.transfer_strobe_n && pins_s.chip_on_pin;
  assign rd_bit = reg_q[cnt_q[2:0]];

  // transfer sequencing
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= FGSR_IDLE;
    end else if (!pins_s.chip_on_pin || pins_s.transfer_strobe_n) begin
      st_q <= FGSR_IDLE;
    end else begin
      case (st_q)
        FGSR_IDLE: st_q <= FGSR_CMD;
        FGSR_CMD: begin
          if (rise) begin
            st_q <= pins_s.serial_data ? FGSR_WR : FGSR_RD;
          end
        end
        default: st_q <= st_q;
      endcase
    end
  end

  // bit counter, shared by write capture and read drive
  always_ff @(posedge clock_i) begin
    if (rst_i || st_q == FGSR_IDLE || st_q == FGSR_CMD) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != `FGSR_XFER_BITS &&
                 ((st_q == FGSR_WR && rise) || (st_q == FGSR_RD && fall))) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // write capture, least significant bit enters first and ends at bit 0
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      shift_q <= '0;
    end else if (st_q == FGSR_WR && rise && cnt_q != `FGSR_XFER_BITS &&
                 !pins_s.transfer_strobe_n) begin
      shift_q <= {pins_s.serial_data, shift_q[REG_W-1:1]};
    end
  end

  // the one settings register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_q <= `FGSR_RESET_VAL;
    end else if (commit) begin
      reg_q <= shift_q;
    end
  end

  // readback drive, low outside a read
  always_ff @(posedge clock_i) begin
    if (rst_i || st_q != FGSR_RD || pins_s.transfer_strobe_n) begin
      serial_readback_out_o <= 1'b0;
    end else if (fall && cnt_q != `FGSR_XFER_BITS) begin
      serial_readback_out_o <= rd_bit;
    end
  end

  // applied settings, one copy for both channels
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      settings_o <= '0;
    end else begin
      settings_o <= decode(reg_q, pins_s.chip_on_pin);
    end
  end

  property p_commit_loads;
    @(posedge clock_i) disable iff (rst_i)
    commit |=> reg_q == $past(shift_q);
  endproperty
  a_commit_loads: assert property (p_commit_loads)
    else $error("register not loaded at end of full write");

  property p_no_stray_change;
    @(posedge clock_i) disable iff (rst_i)
    !commit |=> $stable(reg_q);
  endproperty
  a_no_stray_change: assert property (p_no_stray_change)
    else $error("register changed without a completed write");

  property p_corner_off;
    @(posedge clock_i) disable iff (rst_i)
    pins_s.chip_on_pin ##1 pins_s.chip_on_pin |->
      settings_o.signal_on == ($past(reg_q[7:3]) != 5'h00) &&
      settings_o.corner_mhz == $past(reg_q[7:3]);
  endproperty
  a_corner_off: assert property (p_corner_off)
    else $error("corner code not applied");

  property p_buf_gain;
    @(posedge clock_i) disable iff (rst_i)
    pins_s.chip_on_pin |=> settings_o.buf_gain_6db == $past(reg_q[2]);
  endproperty
  a_buf_gain: assert property (p_buf_gain)
    else $error("input buffer gain mismatch");

  property p_post_gain;
    @(posedge clock_i) disable iff (rst_i)
    pins_s.chip_on_pin |=> settings_o.post_gain_12db == $past(reg_q[1]);
  endproperty
  a_post_gain: assert property (p_post_gain)
    else $error("post-filter gain mismatch");

  property p_vga_gain;
    @(posedge clock_i) disable iff (rst_i)
    pins_s.chip_on_pin |=> settings_o.vga_max_28db == $past(reg_q[0]);
  endproperty
  a_vga_gain: assert property (p_vga_gain)
    else $error("maximum gain mismatch");

  property p_disabled;
    @(posedge clock_i) disable iff (rst_i)
    !pins_s.chip_on_pin |=> settings_o == '0 && st_q == FGSR_IDLE;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("device active while disabled");

  property p_cmd_write;
    @(posedge clock_i) disable iff (rst_i)
    st_q == FGSR_CMD && rise && pins_s.serial_data && !pins_s.transfer_strobe_n &&
      pins_s.chip_on_pin |=> st_q == FGSR_WR;
  endproperty
  a_cmd_write: assert property (p_cmd_write)
    else $error("write request not recognised");

  property p_capture;
    @(posedge clock_i) disable iff (rst_i)
    st_q == FGSR_WR && rise && cnt_q < 4'h8 && !pins_s.transfer_strobe_n |=>
      shift_q[7] == $past(pins_s.serial_data) && cnt_q == $past(cnt_q) + 4'h1;
  endproperty
  a_capture: assert property (p_capture)
    else $error("write bit not captured");

  property p_readback;
    @(posedge clock_i) disable iff (rst_i)
    st_q == FGSR_RD && fall && cnt_q < 4'h8 && !pins_s.transfer_strobe_n |=>
      serial_readback_out_o == $past(rd_bit);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback bit wrong");

endmodule : fgsr_top

//--- sim/fgsr_host.sv
// host controller model driving the three-wire settings port
`timescale 1ns/10ps
module fgsr_host (
  // clock
  input  wire logic clock_i,
  // serial port pins
  output logic      strobe_n_o,
  output logic      sclk_o,
  output logic      data_o,
  input  wire logic readback_i
);
  initial begin
    strobe_n_o = 1'b1;
    sclk_o     = 1'b0;
    data_o     = 1'b0;
  end

  // one frame, shift clock period of 8 system clocks (200 ns); n below 8 cuts a write short
  task automatic xfer(input logic wr, input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    strobe_n_o <= 1'b0;
    data_o     <= wr;
    repeat (4) @(posedge clock_i);
    sclk_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    for (int i = 0; i < n; i++) begin
      sclk_o <= 1'b0;
      data_o <= d[i];
      // readback settles 3 clocks after the pin falls; take it just before the rise
      repeat (4) @(posedge clock_i);
      q[i] = readback_i;
      sclk_o <= 1'b1;
      repeat (4) @(posedge clock_i);
    end
    strobe_n_o <= 1'b1;
    // released data line must not keep the last bit
    data_o     <= ~data_o;
    repeat (4) @(posedge clock_i);
    sclk_o <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask : xfer
endmodule : fgsr_host

//--- sim/testbench.sv
// self-checking bench for the filter and gain settings register
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  import fgsr_pkg::*;
  logic           clock_i;
  logic           rst_i;
  logic           chip_on_pin_i;
  logic           strobe_n;
  logic           sclk;
  logic           sdata;
  logic           readback;
  fgsr_settings_t settings;
  logic [7:0]     q;
  int             num_errors = 0;
  int             checks     = 0;
  int             cycles     = 0;
  // written code beside the settings it should give
  logic [16:0]    rows [6] = '{{8'ha5, 9'h1a5}, {8'h07, 9'h007}, {8'hff, 9'h1ff},
                               {8'h08, 9'h108}, {8'h00, 9'h000}, {8'h5a, 9'h15a}};

  fgsr_top uut (
    .clock_i              (clock_i),
    .rst_i                (rst_i),
    .transfer_strobe_n_i  (strobe_n),
    .shift_clk_i          (sclk),
    .serial_data_i        (sdata),
    .chip_on_pin_i        (chip_on_pin_i),
    .serial_readback_out_o(readback),
    .settings_o           (settings)
  );

  fgsr_host host (
    .clock_i   (clock_i),
    .strobe_n_o(strobe_n),
    .sclk_o    (sclk),
    .data_o    (sdata),
    .readback_i(readback)
  );

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // about 1300 cycles of traffic; generous ceiling
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    rst_i         = 1'b1;
    chip_on_pin_i = 1'b1;
    repeat (5) @(posedge clock_i);
    `CHK(settings, 9'h000)
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    `CHK(settings, 9'h000)
    `CHK(readback, 1'b0)
    foreach (rows[i]) begin
      host.xfer(1'b1, rows[i][16:9], 8, q);
      repeat (6) @(posedge clock_i);
      `CHK(settings, rows[i][8:0])
      host.xfer(1'b0, 8'h00, 8, q);
      `CHK(q, rows[i][16:9])
      `CHK(settings, rows[i][8:0])
    end
    // write cut short after four bits must be dropped
    host.xfer(1'b1, 8'h0f, 4, q);
    repeat (6) @(posedge clock_i);
    `CHK(settings, 9'h15a)
    // disabled chip: outputs off, port ignored, code kept
    chip_on_pin_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    `CHK(settings, 9'h000)
    host.xfer(1'b1, 8'h33, 8, q);
    chip_on_pin_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    `CHK(settings, 9'h15a)
    host.xfer(1'b0, 8'h00, 8, q);
    `CHK(q, 8'h5a)
    // second reset in mid-run
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK(settings, 9'h000)
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    host.xfer(1'b0, 8'h00, 8, q);
    `CHK(q, 8'h00)
    report_and_stop();
  end
endmodule : testbench
